// ===== eeprom_ctrl_pkg.sv
// eeprom_ctrl_pkg: shared constants for the eeprom commit controller and its host
// assumes: 8-bit register link between host and device, 40 MHz system clock
package eeprom_ctrl_pkg;

  // link widths
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;

  // device register offsets on the link
  localparam logic [7:0] OFF_CFG_BASE = 8'h00;
  localparam logic [7:0] OFF_COUNT = 8'h88;
  localparam logic [7:0] OFF_CTRL = 8'h89;
  localparam logic [7:0] OFF_LIVE_CRC = 8'h8A;
  localparam logic [7:0] OFF_UNLOCK = 8'h8D;
  localparam logic [7:0] OFF_PAGE = 8'h8E;
  localparam logic [7:0] OFF_AON = 8'h8F;

  // eeprom_control and aon register bit positions
  localparam int BIT_COPY = 6;
  localparam int BIT_CRC_ERR = 5;
  localparam int BIT_AUTO_CRC = 4;
  localparam int BIT_LOAD = 3;
  localparam int BIT_BUSY = 2;
  localparam int BIT_PROG = 0;
  localparam int BIT_AON_KEEP = 0;

  // reset and limit values
  localparam logic [7:0] COUNT_RESET = 8'h00;
  localparam logic [7:0] COUNT_MAX = 8'hFF;
  localparam logic [7:0] ERASED_BYTE = 8'h00;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic AUTO_CRC_RESET = 1'b1;
  localparam logic [7:0] UNLOCK_CODE_DEF = 8'hEA;

  // crc-8, polynomial x^8+x^2+x+1
  localparam logic [7:0] CRC_POLY = 8'h07;
  localparam logic [7:0] CRC_INIT = 8'h00;

  // erase/program duration
  localparam int CLK_HZ = 40_000_000;
  localparam int PROG_TIME_MS = 230;
  localparam int PROG_CYCLES = PROG_TIME_MS * (CLK_HZ / 1000);

  // host wishbone offsets and fields
  localparam logic [7:0] WB_CMD = 8'h00;
  localparam logic [7:0] WB_GO = 8'h04;
  localparam logic [7:0] WB_STATUS = 8'h08;
  localparam int CMD_DATA_LSB = 0;
  localparam int CMD_ADDR_LSB = 8;
  localparam int CMD_WE_BIT = 16;
  localparam int CMD_PROG_BIT = 17;
  localparam int ST_RDATA_LSB = 0;
  localparam int ST_ERR_BIT = 8;
  localparam int ST_BUSY_BIT = 9;
  localparam logic [31:0] WB_ZERO = 32'h0000_0000;

  // one byte through the crc
  function automatic logic [7:0] crc8_step(input logic [7:0] crc, input logic [7:0] data);
    logic [7:0] c;
    c = crc ^ data;
    for (int b = 0; b < 8; b++) begin
      c = c[7] ? ((c << 1) ^ CRC_POLY) : (c << 1);
    end
    return c;
  endfunction

endpackage

// ===== eeprom_link_if.sv
// eeprom_link_if: byte-wide register link between host and eeprom device
// assumes: one clock shared by both ends; each access is one link transaction
`timescale 1ns/10ps
`default_nettype none
interface eeprom_link_if (
  input wire logic clk_i,
  input wire logic rst_i
);
  logic req;
  logic we;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic ack;
  logic err;

  modport dev (input clk_i, input rst_i, input req, input we, input addr, input wdata,
               output rdata, output ack, output err);
  modport host (input clk_i, input rst_i, input rdata, input ack, input err,
                output req, output we, output addr, output wdata);
endinterface
`default_nettype wire

// ===== eeprom_commit_dev.sv
// eeprom_commit_dev: eeprom load/program/copy control with cycle counter and crc
// assumes: link driven by eeprom_commit_host; array, sram page held here in flops
`timescale 1ns/10ps
`default_nettype none

// Contract
// - count increments after each erase/program cycle
// - count stops at 255
// - count reloaded after reset, load, program
// - copy bit copies registers to selected page
// - crc mismatch on load sets error flag
// - auto crc enable stores crc on program
// - load after reset and on load bit
// - no register reads during a load
// - load advances only while aon clock runs
// - busy high for whole program cycle
// - program starts only right after unlock
// - program cycle lasts about 230 ms
// - live crc computed during load, readable
module eeprom_commit_dev #(
  parameter int CFG_BYTES = 8,
  parameter int NUM_PAGES = 2,
  parameter int PROG_CYCLES = eeprom_ctrl_pkg::PROG_CYCLES,
  parameter logic [7:0] UNLOCK_CODE = eeprom_ctrl_pkg::UNLOCK_CODE_DEF
) (
  // register link
  eeprom_link_if.dev link,
  // always-on clock status and keep request
  input wire logic aon_clk_active_i,
  output logic keep_aon_o,
  // live configuration and activity
  output logic [CFG_BYTES*8-1:0] live_cfg_o,
  output logic program_busy_o,
  output logic load_active_o
);

  localparam int IDX_W = $clog2(CFG_BYTES);
  localparam int PAGE_W = $clog2(NUM_PAGES);
  localparam logic [IDX_W-1:0] IDX_LAST = IDX_W'(CFG_BYTES - 1);
  localparam logic [31:0] PROG_LAST = 32'(PROG_CYCLES - 1);

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_LOAD = 3'b001,
    ST_PROG = 3'b010,
    ST_REFRESH = 3'b011,
    ST_COPY = 3'b100
  } state_t;

  logic clk;
  logic rst;
  state_t state_reg;
  logic [IDX_W-1:0] idx_reg;
  logic [31:0] timer_reg;
  logic [7:0] live_reg [CFG_BYTES];
  logic [7:0] nvm_reg [CFG_BYTES];
  logic [7:0] sram_reg [NUM_PAGES][CFG_BYTES];
  logic [7:0] nvm_count_reg;
  logic [7:0] nvm_crc_reg;
  logic [7:0] count_reg;
  logic [7:0] live_crc_reg;
  logic crc_err_reg;
  logic auto_crc_reg;
  logic [PAGE_W-1:0] page_reg;
  logic aon_reg;
  logic unlock_ok_reg;
  logic ack_reg;
  logic err_reg;
  logic [7:0] rdata_reg;
  logic acc;
  logic wr;
  logic wr_ctrl;
  logic start_prog;
  logic start_load;
  logic start_copy;
  logic cfg_hit;
  logic [7:0] ctrl_val;
  logic [7:0] rd_val;
  logic [7:0] full_crc;

  assign clk = link.clk_i;
  assign rst = link.rst_i;

  //////////////////////////////////////////////////////////////////////////////
  // link decode

  // one access per request; the cycle of ack is blind so a held request is not taken twice
  assign acc = link.req && !ack_reg;
  assign wr = acc && link.we && (state_reg != ST_LOAD);
  assign wr_ctrl = wr && (link.addr == eeprom_ctrl_pkg::OFF_CTRL);
  assign cfg_hit = link.addr < 8'(CFG_BYTES);
  // starts only from idle; program wins over load, load over copy
  assign start_prog = wr_ctrl && link.wdata[eeprom_ctrl_pkg::BIT_PROG] && unlock_ok_reg
                      && (state_reg == ST_IDLE);
  assign start_load = wr_ctrl && link.wdata[eeprom_ctrl_pkg::BIT_LOAD] && !start_prog
                      && (state_reg == ST_IDLE);
  assign start_copy = wr_ctrl && link.wdata[eeprom_ctrl_pkg::BIT_COPY] && !start_prog
                      && !link.wdata[eeprom_ctrl_pkg::BIT_LOAD] && (state_reg == ST_IDLE);

  // crc over the whole live image, stored on program
  always_comb begin
    full_crc = eeprom_ctrl_pkg::CRC_INIT;
    for (int i = 0; i < CFG_BYTES; i++) begin
      full_crc = eeprom_ctrl_pkg::crc8_step(full_crc, live_reg[i]);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // sequencer

  // reset enters load so the image is fetched at power up
  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= ST_LOAD;
      idx_reg <= '0;
      timer_reg <= '0;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          idx_reg <= '0;
          timer_reg <= '0;
          if (start_prog) begin
            state_reg <= ST_PROG;
          end else if (start_load) begin
            state_reg <= ST_LOAD;
          end else if (start_copy) begin
            state_reg <= ST_COPY;
          end
        end
        ST_LOAD: begin
          // a stopped always-on clock freezes the load in place
          if (aon_clk_active_i) begin
            idx_reg <= idx_reg + 1'b1;
            if (idx_reg == IDX_LAST) begin
              state_reg <= ST_REFRESH;
            end
          end
        end
        ST_PROG: begin
          timer_reg <= timer_reg + 32'h0000_0001;
          if (timer_reg == PROG_LAST) begin
            state_reg <= ST_REFRESH;
          end
        end
        ST_REFRESH: begin
          state_reg <= ST_IDLE;
        end
        ST_COPY: begin
          idx_reg <= idx_reg + 1'b1;
          if (idx_reg == IDX_LAST) begin
            state_reg <= ST_IDLE;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // live registers and sram pages

  // host writes land in the live image; a load overwrites it byte by byte
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < CFG_BYTES; i++) begin
        live_reg[i] <= eeprom_ctrl_pkg::ERASED_BYTE;
      end
    end else if (state_reg == ST_LOAD && aon_clk_active_i) begin
      live_reg[idx_reg] <= nvm_reg[idx_reg];
    end else if (wr && cfg_hit) begin
      live_reg[link.addr[IDX_W-1:0]] <= link.wdata;
    end
  end

  // copy walks one byte per cycle into the page chosen at start
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int p = 0; p < NUM_PAGES; p++) begin
        for (int i = 0; i < CFG_BYTES; i++) begin
          sram_reg[p][i] <= eeprom_ctrl_pkg::ERASED_BYTE;
        end
      end
    end else if (state_reg == ST_COPY) begin
      sram_reg[page_reg][idx_reg] <= live_reg[idx_reg];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // nonvolatile array

  // array is cleared by reset only because it has no real cell model here
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < CFG_BYTES; i++) begin
        nvm_reg[i] <= eeprom_ctrl_pkg::ERASED_BYTE;
      end
      nvm_count_reg <= eeprom_ctrl_pkg::COUNT_RESET;
      nvm_crc_reg <= eeprom_ctrl_pkg::CRC_INIT;
    end else if (state_reg == ST_PROG && timer_reg == PROG_LAST) begin
      for (int i = 0; i < CFG_BYTES; i++) begin
        nvm_reg[i] <= live_reg[i];
      end
      if (auto_crc_reg) begin
        nvm_crc_reg <= full_crc;
      end
      if (nvm_count_reg != eeprom_ctrl_pkg::COUNT_MAX) begin
        nvm_count_reg <= nvm_count_reg + 8'h01;
      end
    end
  end

  // visible count follows the array after load and after program
  always_ff @(posedge clk) begin
    if (rst) begin
      count_reg <= eeprom_ctrl_pkg::COUNT_RESET;
    end else if (state_reg == ST_REFRESH) begin
      count_reg <= nvm_count_reg;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // crc check

  // running crc restarts with each load and stays readable afterwards
  always_ff @(posedge clk) begin
    if (rst) begin
      live_crc_reg <= eeprom_ctrl_pkg::CRC_INIT;
    end else if (start_load) begin
      live_crc_reg <= eeprom_ctrl_pkg::CRC_INIT;
    end else if (state_reg == ST_LOAD && aon_clk_active_i) begin
      live_crc_reg <= eeprom_ctrl_pkg::crc8_step(live_crc_reg, nvm_reg[idx_reg]);
    end
  end

  // flag judged at the end of each load, so a good load clears an old error
  always_ff @(posedge clk) begin
    if (rst) begin
      crc_err_reg <= 1'b0;
    end else if (state_reg == ST_LOAD && aon_clk_active_i && idx_reg == IDX_LAST) begin
      crc_err_reg <= eeprom_ctrl_pkg::crc8_step(live_crc_reg, nvm_reg[idx_reg]) != nvm_crc_reg;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // software settings and unlock

  always_ff @(posedge clk) begin
    if (rst) begin
      auto_crc_reg <= eeprom_ctrl_pkg::AUTO_CRC_RESET;
      page_reg <= '0;
      aon_reg <= 1'b0;
    end else if (wr) begin
      if (link.addr == eeprom_ctrl_pkg::OFF_CTRL) begin
        auto_crc_reg <= link.wdata[eeprom_ctrl_pkg::BIT_AUTO_CRC];
      end
      if (link.addr == eeprom_ctrl_pkg::OFF_PAGE && state_reg != ST_COPY) begin
        page_reg <= link.wdata[PAGE_W-1:0];
      end
      if (link.addr == eeprom_ctrl_pkg::OFF_AON) begin
        aon_reg <= link.wdata[eeprom_ctrl_pkg::BIT_AON_KEEP];
      end
    end
  end

  // unlock holds only across the single next transaction
  always_ff @(posedge clk) begin
    if (rst) begin
      unlock_ok_reg <= 1'b0;
    end else if (acc) begin
      unlock_ok_reg <= wr && link.addr == eeprom_ctrl_pkg::OFF_UNLOCK && link.wdata == UNLOCK_CODE;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // read path and answer

  always_comb begin
    ctrl_val = eeprom_ctrl_pkg::ZERO_BYTE;
    ctrl_val[eeprom_ctrl_pkg::BIT_COPY] = state_reg == ST_COPY;
    ctrl_val[eeprom_ctrl_pkg::BIT_CRC_ERR] = crc_err_reg;
    ctrl_val[eeprom_ctrl_pkg::BIT_AUTO_CRC] = auto_crc_reg;
    ctrl_val[eeprom_ctrl_pkg::BIT_BUSY] = state_reg == ST_PROG;
    rd_val = eeprom_ctrl_pkg::ZERO_BYTE;
    if (cfg_hit) begin
      rd_val = live_reg[link.addr[IDX_W-1:0]];
    end else if (link.addr == eeprom_ctrl_pkg::OFF_COUNT) begin
      rd_val = count_reg;
    end else if (link.addr == eeprom_ctrl_pkg::OFF_CTRL) begin
      rd_val = ctrl_val;
    end else if (link.addr == eeprom_ctrl_pkg::OFF_LIVE_CRC) begin
      rd_val = live_crc_reg;
    end else if (link.addr == eeprom_ctrl_pkg::OFF_PAGE) begin
      rd_val = 8'(page_reg);
    end else if (link.addr == eeprom_ctrl_pkg::OFF_AON) begin
      rd_val = {7'h00, aon_reg};
    end
  end

  // answer one cycle after the request; during a load every access is refused
  always_ff @(posedge clk) begin
    if (rst) begin
      ack_reg <= 1'b0;
      err_reg <= 1'b0;
      rdata_reg <= eeprom_ctrl_pkg::ZERO_BYTE;
    end else begin
      ack_reg <= acc;
      if (acc) begin
        err_reg <= state_reg == ST_LOAD;
        rdata_reg <= (state_reg == ST_LOAD || link.we) ? eeprom_ctrl_pkg::ZERO_BYTE : rd_val;
      end
    end
  end

  assign link.ack = ack_reg;
  assign link.err = err_reg;
  assign link.rdata = rdata_reg;
  assign keep_aon_o = aon_reg;
  assign program_busy_o = state_reg == ST_PROG;
  assign load_active_o = state_reg == ST_LOAD;

  // flattened live image for the clock datapath
  for (genvar g = 0; g < CFG_BYTES; g++) begin : g_live
    assign live_cfg_o[g*8 +: 8] = live_reg[g];
  end

endmodule
`default_nettype wire

// ===== eeprom_commit_host.sv
// eeprom_commit_host: wishbone-fed host that issues link accesses to the eeprom device
// assumes: classic wishbone master on one side, eeprom_commit_dev on the link
`timescale 1ns/10ps
`default_nettype none
module eeprom_commit_host (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic [7:0] adr_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  input wire logic we_i,
  input wire logic [3:0] sel_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  output logic ack_o,
  // register link
  eeprom_link_if.host link
);

  typedef enum logic [2:0] {
    H_IDLE = 3'b000,
    H_SINGLE = 3'b001,
    H_UNLOCK = 3'b010,
    H_START = 3'b011,
    H_POLL = 3'b100
  } hstate_t;

  hstate_t state_reg;
  logic [31:0] cmd_reg;
  logic req_reg;
  logic [7:0] addr_reg;
  logic we_reg;
  logic [7:0] wdata_reg;
  logic [7:0] result_reg;
  logic err_reg;
  logic wb_ack_reg;
  logic [31:0] wb_rdata_reg;
  logic wb_acc;
  logic go;
  logic busy_seen;

  //////////////////////////////////////////////////////////////////////////////
  // wishbone slave

  // registered ack, one cycle after the strobe; unmapped reads give zero
  assign wb_acc = cyc_i && stb_i && !wb_ack_reg;
  assign go = wb_acc && we_i && adr_i == eeprom_ctrl_pkg::WB_GO && state_reg == H_IDLE;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_reg <= 1'b0;
      wb_rdata_reg <= eeprom_ctrl_pkg::WB_ZERO;
    end else begin
      wb_ack_reg <= wb_acc;
      if (wb_acc) begin
        wb_rdata_reg <= eeprom_ctrl_pkg::WB_ZERO;
        if (adr_i == eeprom_ctrl_pkg::WB_CMD) begin
          wb_rdata_reg <= cmd_reg;
        end else if (adr_i == eeprom_ctrl_pkg::WB_STATUS) begin
          wb_rdata_reg[eeprom_ctrl_pkg::ST_RDATA_LSB +: 8] <= result_reg;
          wb_rdata_reg[eeprom_ctrl_pkg::ST_ERR_BIT] <= err_reg;
          wb_rdata_reg[eeprom_ctrl_pkg::ST_BUSY_BIT] <= state_reg != H_IDLE;
        end
      end
    end
  end

  // command word honours byte enables
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cmd_reg <= eeprom_ctrl_pkg::WB_ZERO;
    end else if (wb_acc && we_i && adr_i == eeprom_ctrl_pkg::WB_CMD) begin
      for (int b = 0; b < 4; b++) begin
        if (sel_i[b]) begin
          cmd_reg[b*8 +: 8] <= dat_i[b*8 +: 8];
        end
      end
    end
  end

  assign ack_o = wb_ack_reg;
  assign dat_o = wb_rdata_reg;

  //////////////////////////////////////////////////////////////////////////////
  // link sequencer

  // program is sent as unlock then start with nothing between, then busy is polled
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= H_IDLE;
    end else begin
      unique case (state_reg)
        H_IDLE: begin
          if (go) begin
            state_reg <= cmd_reg[eeprom_ctrl_pkg::CMD_PROG_BIT] ? H_UNLOCK : H_SINGLE;
          end
        end
        H_SINGLE: begin
          if (link.ack) begin
            state_reg <= H_IDLE;
          end
        end
        H_UNLOCK: begin
          if (link.ack) begin
            state_reg <= H_START;
          end
        end
        H_START: begin
          if (link.ack) begin
            state_reg <= H_POLL;
          end
        end
        H_POLL: begin
          // a refused read says nothing, so it is simply asked again
          if (link.ack && !link.err && !busy_seen) begin
            state_reg <= H_IDLE;
          end
        end
        default: begin
          state_reg <= H_IDLE;
        end
      endcase
    end
  end

  assign busy_seen = link.rdata[eeprom_ctrl_pkg::BIT_BUSY];

  // request raised when idle on the link, dropped at the ack edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      req_reg <= 1'b0;
      addr_reg <= eeprom_ctrl_pkg::ZERO_BYTE;
      we_reg <= 1'b0;
      wdata_reg <= eeprom_ctrl_pkg::ZERO_BYTE;
    end else if (link.ack || state_reg == H_IDLE) begin
      req_reg <= 1'b0;
    end else if (!req_reg) begin
      req_reg <= 1'b1;
      unique case (state_reg)
        H_UNLOCK: begin
          addr_reg <= eeprom_ctrl_pkg::OFF_UNLOCK;
          we_reg <= 1'b1;
          wdata_reg <= cmd_reg[eeprom_ctrl_pkg::CMD_ADDR_LSB +: 8];
        end
        H_START: begin
          addr_reg <= eeprom_ctrl_pkg::OFF_CTRL;
          we_reg <= 1'b1;
          wdata_reg <= cmd_reg[eeprom_ctrl_pkg::CMD_DATA_LSB +: 8];
          wdata_reg[eeprom_ctrl_pkg::BIT_PROG] <= 1'b1;
        end
        H_POLL: begin
          addr_reg <= eeprom_ctrl_pkg::OFF_CTRL;
          we_reg <= 1'b0;
          wdata_reg <= eeprom_ctrl_pkg::ZERO_BYTE;
        end
        default: begin
          addr_reg <= cmd_reg[eeprom_ctrl_pkg::CMD_ADDR_LSB +: 8];
          we_reg <= cmd_reg[eeprom_ctrl_pkg::CMD_WE_BIT];
          wdata_reg <= cmd_reg[eeprom_ctrl_pkg::CMD_DATA_LSB +: 8];
        end
      endcase
    end
  end

  // last answer kept for software
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      result_reg <= eeprom_ctrl_pkg::ZERO_BYTE;
      err_reg <= 1'b0;
    end else if (link.ack) begin
      result_reg <= link.rdata;
      err_reg <= link.err;
    end
  end

  assign link.req = req_reg;
  assign link.addr = addr_reg;
  assign link.we = we_reg;
  assign link.wdata = wdata_reg;

endmodule
`default_nettype wire

// ===== eeprom_program_commit_control_chk.sv
// checker: link handshake and device activity properties
// assumes: instanced in the bench beside the link interface
`timescale 1ns/10ps
`default_nettype none
module eeprom_program_commit_control_chk #(
  parameter int CFG_BYTES = 8,
  parameter int PROG_CYCLES = 20
) (
  // clock, reset, link
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic req,
  input wire logic we,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic ack,
  input wire logic err,
  // device side
  input wire logic aon_clk_active_i,
  input wire logic keep_aon_o,
  input wire logic program_busy_o,
  input wire logic load_active_o
);
  localparam logic [7:0] A_CTRL = eeprom_ctrl_pkg::OFF_CTRL;
  localparam logic [7:0] A_UNL = eeprom_ctrl_pkg::OFF_UNLOCK;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic unl_reg;
  logic [31:0] busy_cnt;
  logic [31:0] load_cnt;
  ////////////////////
  // any taken access ends the unlock window
  always_ff @(posedge clk_i) begin
    if (rst_i) unl_reg <= 1'b0;
    else if (req && !ack) unl_reg <= we && addr == A_UNL && wdata == eeprom_ctrl_pkg::UNLOCK_CODE_DEF;
  end
  // stalled load cycles are not counted, so the length check holds with a paused clock
  always_ff @(posedge clk_i) begin
    busy_cnt <= program_busy_o ? busy_cnt + 32'h1 : 32'h0;
    load_cnt <= (load_active_o && !rst_i) ? load_cnt + {31'h0, aon_clk_active_i} : 32'h0;
  end
  ////////////////////
  sequence s_take;
    req && !ack;
  endsequence
  sequence s_ctrl_go;
    s_take ##0 (we && addr == A_CTRL && !program_busy_o && !load_active_o);
  endsequence
  AST_ACK_PULSE: assert property (ack |=> !ack) else $error("ack longer than a cycle");
  AST_REFUSE: assert property (s_take ##0 load_active_o |=> ack && err) else $error("access in load not refused");
  AST_ANSWER: assert property (s_take ##0 !load_active_o |=> ack && !err) else $error("idle access refused");
  AST_PROG_START: assert property (s_ctrl_go ##0 (wdata[0] && unl_reg) |=> program_busy_o)
    else $error("unlocked start ignored");
  AST_PROG_LOCKED: assert property (s_ctrl_go ##0 !unl_reg |=> !program_busy_o)
    else $error("locked start taken");
  AST_BUSY_LEN: assert property ($fell(program_busy_o) |-> busy_cnt == PROG_CYCLES)
    else $error("program length wrong");
  AST_BUSY_HOLD: assert property ($rose(program_busy_o) |=> program_busy_o [*8]) else $error("busy dropped");
  AST_LOAD_STALL: assert property (load_active_o && !aon_clk_active_i |=> load_active_o)
    else $error("load ran without aon");
  AST_LOAD_LEN: assert property ($fell(load_active_o) |-> load_cnt >= CFG_BYTES && load_cnt <= CFG_BYTES + 1)
    else $error("load length wrong");
  AST_LOAD_AFTER_RESET: assert property ($fell(rst_i) |-> load_active_o) else $error("no load after reset");
  AST_LOAD_START: assert property (s_ctrl_go ##0 (wdata[3] && !wdata[0]) |-> ##[1:2] load_active_o)
    else $error("load bit ignored");
  AST_KEEP_AON: assert property (s_take ##0 (we && addr == eeprom_ctrl_pkg::OFF_AON && !load_active_o)
    |=> keep_aon_o == $past(wdata[0])) else $error("keep aon not written");
endmodule
`default_nettype wire

// ===== eeprom_program_commit_control_bench.sv
// bench: both ends joined by the link, software side over wishbone
// assumes: package, interface, design and checker compiled first
`timescale 1ns/10ps
`default_nettype none
module eeprom_program_commit_control_bench;
  localparam int PROG_N = 20;
  localparam logic [7:0] CODE = eeprom_ctrl_pkg::UNLOCK_CODE_DEF;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic aon = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat = 32'h0;
  logic we = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic [31:0] dat_o;
  logic ack_o;
  logic keep_aon;
  logic [63:0] live_cfg;
  logic busy;
  logic loading;
  int n_fail = 0;
  int total_checks = 0;
  ////////////////////
  eeprom_link_if lnk (.clk_i(clk_i), .rst_i(rst_i));
  eeprom_commit_dev #(.PROG_CYCLES(PROG_N)) eeprom_commit_dev_inst (.link(lnk), .aon_clk_active_i(aon),
    .keep_aon_o(keep_aon), .live_cfg_o(live_cfg), .program_busy_o(busy), .load_active_o(loading));
  eeprom_commit_host eeprom_commit_host_inst (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr), .dat_i(dat),
    .dat_o(dat_o), .we_i(we), .sel_i(4'hF), .cyc_i(cyc), .stb_i(stb), .ack_o(ack_o), .link(lnk));
  eeprom_program_commit_control_chk #(.CFG_BYTES(8), .PROG_CYCLES(PROG_N)) chk_inst (.clk_i(clk_i),
    .rst_i(rst_i), .req(lnk.req), .we(lnk.we), .addr(lnk.addr), .wdata(lnk.wdata), .ack(lnk.ack),
    .err(lnk.err), .aon_clk_active_i(aon), .keep_aon_o(keep_aon), .program_busy_o(busy),
    .load_active_o(loading));
  // 40 MHz
  always #12.5 clk_i = ~clk_i;
  ////////////////////
  task automatic chk(input string n, input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", n, exp, got);
    end
  endtask
  // classic cycle; read data taken only at the ack edge
  task automatic wb(input logic [7:0] a, input logic [31:0] d, input logic w, output logic [31:0] q);
    @(posedge clk_i);
    adr <= a;
    dat <= d;
    we <= w;
    cyc <= 1'b1;
    stb <= 1'b1;
    do @(posedge clk_i); while (ack_o !== 1'b1);
    q = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  // one host command, polled to completion through status
  task automatic op(input logic w, input logic p, input logic [7:0] a, input logic [7:0] d,
                    output logic [7:0] r, output logic e);
    logic [31:0] q;
    wb(eeprom_ctrl_pkg::WB_CMD, {14'h0000, p, w, a, d}, 1'b1, q);
    wb(eeprom_ctrl_pkg::WB_GO, 32'h0, 1'b1, q);
    do wb(eeprom_ctrl_pkg::WB_STATUS, 32'h0, 1'b0, q); while (q[9] !== 1'b0);
    r = q[7:0];
    e = q[8];
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] r;
    logic e;
    op(1'b1, 1'b0, a, d, r, e);
  endtask
  task automatic prog(input logic [7:0] code, input logic [7:0] d);
    logic [7:0] r;
    logic e;
    op(1'b1, 1'b1, code, d, r, e);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp, input logic ee, input string n);
    logic [7:0] r;
    logic e;
    op(1'b0, 1'b0, a, 8'h00, r, e);
    chk(n, r, exp);
    chk(n, {7'h00, e}, {7'h00, ee});
  endtask
  function automatic logic [7:0] crc_step(input logic [7:0] c, input logic [7:0] d);
    c = c ^ d;
    for (int b = 0; b < 8; b++) c = c[7] ? ((c << 1) ^ eeprom_ctrl_pkg::CRC_POLY) : (c << 1);
    return c;
  endfunction
  ////////////////////
  task automatic t_reset();
    logic [31:0] q;
    chk("load_in_reset", {7'h00, loading}, 8'h01);
    rst_i <= 1'b0;
    rchk(8'h88, 8'h00, 1'b1, "refused_read");
    chk("load_stalls", {7'h00, loading}, 8'h01);
    aon <= 1'b1;
    repeat (12) @(posedge clk_i);
    rchk(8'h88, 8'h00, 1'b0, "count_reset");
    rchk(8'h89, 8'h10, 1'b0, "ctrl_reset");
    wb(8'h40, 32'h0, 1'b0, q);
    chk("unmapped", q[7:0], 8'h00);
    $display("t_reset done");
  endtask
  task automatic t_prog();
    prog(CODE, 8'h10);
    rchk(8'h88, 8'h01, 1'b0, "count_one");
    rchk(8'h89, 8'h10, 1'b0, "busy_clear");
    prog(~CODE, 8'h10);
    wr(8'h89, 8'h11);
    chk("no_start", {7'h00, busy}, 8'h00);
    rchk(8'h88, 8'h01, 1'b0, "count_kept");
    $display("t_prog done");
  endtask
  // auto crc off leaves a stale stored crc, so the next load must flag it
  task automatic t_load();
    logic [7:0] c;
    c = 8'h00;
    for (int i = 0; i < 8; i++) c = crc_step(c, (i == 0) ? 8'h01 : 8'h00);
    wr(8'h00, 8'h01);
    wr(8'h8F, 8'h01);
    chk("keep_aon", {7'h00, keep_aon}, 8'h01);
    prog(CODE, 8'h00);
    // spoil byte 0 so only the load can bring back the programmed value
    wr(8'h00, 8'h55);
    aon <= 1'b0;
    wr(8'h89, 8'h08);
    rchk(8'h88, 8'h00, 1'b1, "read_in_load");
    aon <= 1'b1;
    repeat (12) @(posedge clk_i);
    rchk(8'h89, 8'h20, 1'b0, "crc_error_set");
    rchk(8'h8A, c, 1'b0, "live_crc");
    rchk(8'h88, 8'h02, 1'b0, "count_reload");
    chk("cfg_loaded", live_cfg[7:0], 8'h01);
    prog(CODE, 8'h10);
    wr(8'h89, 8'h18);
    repeat (12) @(posedge clk_i);
    rchk(8'h89, 8'h10, 1'b0, "crc_stored");
    $display("t_load done");
  endtask
  task automatic t_copy();
    wr(8'h8E, 8'h01);
    wr(8'h89, 8'h50);
    repeat (10) @(posedge clk_i);
    rchk(8'h89, 8'h10, 1'b0, "copy_done");
    $display("t_copy done");
  endtask
  task automatic t_sat();
    repeat (252) prog(CODE, 8'h10);
    rchk(8'h88, 8'hFF, 1'b0, "count_max");
    prog(CODE, 8'h10);
    rchk(8'h88, 8'hFF, 1'b0, "count_saturates");
    $display("t_sat done");
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  ////////////////////
  // main sequence
  initial begin
    repeat (10) @(posedge clk_i);
    t_reset();
    t_prog();
    t_load();
    t_copy();
    t_sat();
    stop_test();
  end
  // watchdog, well above the expected run
  initial begin
    repeat (60000) @(posedge clk_i);
    n_fail++;
    stop_test();
  end
endmodule
`default_nettype wire
